// ### verilog/ire_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and types of the interrupt-return epilogue
package ire_pkg;
  // ========================================================
  // Register byte offsets on the APB slave
  localparam logic [11:0] IRE_OFF_CTRL   = 12'h000; // Epilogue control
  localparam logic [11:0] IRE_OFF_STATUS = 12'h004; // Status word
  localparam logic [11:0] IRE_OFF_SHADOW = 12'h008; // Shadow-set control
  localparam logic [11:0] IRE_OFF_EPC    = 12'h00C; // Exception PC
  localparam logic [11:0] IRE_OFF_VBASE  = 12'h010; // Vector base
  localparam logic [11:0] IRE_OFF_SP     = 12'h014; // Register 29 of current set
  localparam logic [11:0] IRE_OFF_PC     = 12'h018; // Program counter
  localparam logic [11:0] IRE_OFF_CAUSE  = 12'h01C; // Cause and core flags
  localparam logic [11:0] IRE_OFF_FAULT  = 12'h020; // Faulting address
  localparam logic [11:0] IRE_OFF_TFAULT = 12'h024; // Translation fault word
  localparam logic [11:0] IRE_OFF_CFAULT = 12'h028; // Cache fault word
  // ========================================================
  // Control register fields
  localparam int IRE_CTL_APE    = 0;  // Auto prologue enable
  localparam int IRE_CTL_ICE    = 1;  // Chaining enable
  localparam int IRE_CTL_CLR    = 2;  // Clear level on chain
  localparam int IRE_CTL_IV     = 3;  // Vector select
  localparam int IRE_CTL_VS     = 4;  // Vector spacing, 5 bits
  localparam int IRE_CTL_STACK_DECREMENT = 9;  // Stack decrement, 5 bits
  // Status register fields
  localparam int IRE_ST_IE  = 0;      // Interrupt enable
  localparam int IRE_ST_EXL = 1;      // Exception level
  localparam int IRE_ST_ERL = 2;      // Error level
  localparam int IRE_ST_KSU = 3;      // Privilege mode, 2 bits
  localparam int IRE_ST_IPL = 10;     // Priority level, 6 bits
  localparam int IRE_ST_BEV = 22;     // Boot vectors
  // Shadow-set control fields, 4 bits each
  localparam int IRE_SH_CSS = 0;      // Current shadow set
  localparam int IRE_SH_PSS = 6;      // Previous shadow set
  localparam int IRE_SH_ESS = 18;     // Controller shadow set
  localparam int IRE_SH_HSS = 26;     // Highest shadow set
  // Cause register fields
  localparam int IRE_CA_LINK = 0;     // Link flag
  localparam int IRE_CA_ISA  = 1;     // Instruction set state
  localparam int IRE_CA_REQUESTED_PRIORITY_LEVEL = 10;    // Requested priority level, 6 bits
  localparam int IRE_CA_IC   = 25;    // Interrupt chained flag
  // ========================================================
  // Reset values
  localparam logic [31:0] IRE_STATUS_RST = 32'h0040_0004; // Boot vectors, error level
  localparam logic [31:0] IRE_ZERO_RST   = 32'h0000_0000; // All other words
  // Stack frame word offsets
  localparam logic [31:0] IRE_STK_STATUS = 32'h0000_0004;
  localparam logic [31:0] IRE_STK_SHADOW = 32'h0000_0008;
  localparam logic [31:0] IRE_STK_EPC    = 32'h0000_0000;
  // Vector constants
  localparam logic [31:0] IRE_VEC_BOOT   = 32'hBFC0_0200;
  localparam logic [31:0] IRE_VEC_LEGACY = 32'h8000_0000;
  localparam logic [31:0] IRE_VOFF_GEN   = 32'h0000_0180;
  localparam logic [31:0] IRE_VOFF_INT   = 32'h0000_0200;
  // ========================================================
  // Memory fault codes presented with mem_ack, then the epilogue's own unaligned-word code
  localparam logic [2:0] IRE_MF_NONE  = 3'h0;
  localparam logic [2:0] IRE_MF_PRIV  = 3'h1;
  localparam logic [2:0] IRE_MF_REFIL = 3'h2;
  localparam logic [2:0] IRE_MF_INVAL = 3'h3;
  localparam logic [2:0] IRE_MF_CACHE = 3'h4;
  localparam logic [2:0] IRE_MF_BUS   = 3'h5;
  localparam logic [2:0] IRE_EX_ADDR  = 3'h6; // Unaligned stack word
  // ========================================================
  // Sequence states and stack load selection
  typedef enum logic [1:0] {
    IRE_IDLE = 2'b00,
    IRE_LOAD = 2'b01,
    IRE_WAIT = 2'b10
  } ire_state_t;
  typedef enum logic [1:0] {
    IRE_SEL_STATUS = 2'b00,
    IRE_SEL_SHADOW = 2'b01,
    IRE_SEL_EPC    = 2'b10
  } ire_sel_t;
  // Whole state of the block
  typedef struct packed {
    ire_state_t        state;
    ire_sel_t          sel;
    logic [31:0]       ctrl, status, shadow, exception_pc, vbase, pc;
    logic              isa, link, ic;
    logic [5:0]        requested_priority_level;
    logic [15:0][31:0] sp;
    logic [31:0]       fault, tfault, cfault, tmp_shadow;
    logic [31:0]       mem_addr, prdata;
    logic              mem_req, eic_accept, exception_return_req, hazard;
    logic              flush, redirect, exc_valid, pslverr;
    logic [2:0]        exc_code;
  } ire_regs_t;
endpackage : ire_pkg
`default_nettype wire

// ### verilog/ire_epilogue.sv
`default_nettype none
module ire_epilogue #(
  parameter int ARCH_REV   = 2, // Architecture revision
  parameter bit COMPRESSED = 1  // Compressed instruction set present
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pipeline side
  input  wire logic        interrupt_return_epilogue_issue,
  input  wire logic [31:0] interrupt_return_epilogue_pc,
  input  wire logic        interrupt_return_epilogue_isa,
  output logic             flush_next,
  output logic             exception_return_request,
  output logic             hazard_barrier,
  output logic             redirect_valid,
  output logic [31:0]      redirect_pc,
  output logic             redirect_isa,
  output logic             busy,
  // Stack memory
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire logic [2:0]  mem_fault,
  // External interrupt controller
  input  wire logic [5:0]  eic_requested_priority_level,
  input  wire logic [3:0]  eic_ss,
  input  wire logic        eic_updated,
  output logic             eic_accept,
  // Exception report
  output logic             exc_valid,
  output logic [2:0]       exc_code
);
  import ire_pkg::*;

  // ========================================================
  // Elaboration checks
  if (ARCH_REV < 1) begin : g_bad_rev
    $error("ARCH_REV must be at least 1");
  end

  // ========================================================
  // Helpers
  // Stack frame size from the decrement field
  function automatic logic [31:0] ire_frame(input logic [31:0] ctl);
    ire_frame = {25'h000_0000, ctl[IRE_CTL_STACK_DECREMENT +: 5], 2'b00};
  endfunction : ire_frame

  // Chained vector address
  function automatic logic [31:0] ire_vector(input logic [31:0] ctl,
                                             input logic [31:0] st,
                                             input logic [31:0] vb,
                                             input logic [5:0]  lvl);
    logic [31:0] base;
    logic [31:0] offs;
    if (st[IRE_ST_BEV]) begin
      base = IRE_VEC_BOOT;
    end else if (ARCH_REV >= 2) begin
      base = {vb[31:12], 12'h000};
    end else begin
      base = IRE_VEC_LEGACY;
    end
    if (!ctl[IRE_CTL_IV]) begin
      offs = IRE_VOFF_GEN;
    end else if (st[IRE_ST_BEV] || ctl[IRE_CTL_VS +: 5] == 5'h00) begin
      offs = IRE_VOFF_INT;
    end else begin
      // Vector number times the spacing in 32-byte units
      offs = IRE_VOFF_INT + (32'(lvl) * 32'({ctl[IRE_CTL_VS +: 5], 5'h00}));
    end
    ire_vector = base | offs;
  endfunction : ire_vector

  // ========================================================
  // State
  ire_regs_t st_reg;   // Registered state
  ire_regs_t st_next;  // Next state
  logic [3:0]  current_shadow_set;    // Current shadow set
  logic [31:0] sp_cur; // Register 29 of current set
  logic        ret_go; // Restored level wins or no chaining
  logic        wr_acc; // APB write access phase

  assign current_shadow_set    = st_reg.shadow[IRE_SH_CSS +: 4];
  assign sp_cur = st_reg.sp[current_shadow_set];
  assign ret_go = !st_reg.ctrl[IRE_CTL_ICE] ||
                  (mem_rdata[IRE_ST_IPL +: 6] > eic_requested_priority_level);
  assign wr_acc = psel && penable && pwrite && st_reg.state == IRE_IDLE;

  // ========================================================
  // Next-state logic
  always_comb begin
    st_next           = st_reg;
    st_next.flush     = 1'b0;
    st_next.exception_return_req  = 1'b0;
    st_next.hazard    = 1'b0;
    st_next.redirect  = 1'b0;
    st_next.exc_valid = 1'b0;
    // APB setup phase: latch read data and error answer
    if (psel && !penable) begin
      st_next.pslverr = 1'b0;
      unique case (paddr)
        IRE_OFF_CTRL:   st_next.prdata = st_reg.ctrl;
        IRE_OFF_STATUS: st_next.prdata = st_reg.status;
        IRE_OFF_SHADOW: st_next.prdata = st_reg.shadow;
        IRE_OFF_EPC:    st_next.prdata = st_reg.exception_pc;
        IRE_OFF_VBASE:  st_next.prdata = st_reg.vbase;
        IRE_OFF_SP:     st_next.prdata = sp_cur;
        IRE_OFF_PC:     st_next.prdata = st_reg.pc;
        IRE_OFF_CAUSE: begin
          st_next.prdata                   = IRE_ZERO_RST;
          st_next.prdata[IRE_CA_LINK]      = st_reg.link;
          st_next.prdata[IRE_CA_ISA]       = st_reg.isa;
          st_next.prdata[IRE_CA_REQUESTED_PRIORITY_LEVEL +: 6] = st_reg.requested_priority_level;
          st_next.prdata[IRE_CA_IC]        = st_reg.ic;
        end
        IRE_OFF_FAULT:  st_next.prdata = st_reg.fault;
        IRE_OFF_TFAULT: st_next.prdata = st_reg.tfault;
        IRE_OFF_CFAULT: st_next.prdata = st_reg.cfault;
        default: begin
          st_next.prdata  = IRE_ZERO_RST;
          st_next.pslverr = 1'b1;
        end
      endcase
      // Writes while the sequence runs are refused
      if (pwrite && st_reg.state != IRE_IDLE) begin
        st_next.pslverr = 1'b1;
      end
    end
    // APB access phase: writes take effect
    if (wr_acc) begin
      unique case (paddr)
        IRE_OFF_CTRL:   st_next.ctrl    = pwdata;
        IRE_OFF_STATUS: st_next.status  = pwdata;
        IRE_OFF_SHADOW: st_next.shadow  = pwdata;
        IRE_OFF_EPC:    st_next.exception_pc     = pwdata;
        IRE_OFF_VBASE:  st_next.vbase   = pwdata;
        IRE_OFF_SP:     st_next.sp[current_shadow_set] = pwdata;
        IRE_OFF_PC:     st_next.pc      = pwdata;
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
    // Epilogue sequence
    unique case (st_reg.state)
      IRE_IDLE: begin
        if (interrupt_return_epilogue_issue && !wr_acc) begin
          st_next.flush = 1'b1;
          if (!st_reg.ctrl[IRE_CTL_APE] || st_reg.status[IRE_ST_ERL] ||
              st_reg.status[IRE_ST_BEV]) begin
            st_next.exception_return_req = 1'b1;
          end else begin
            st_next.exception_pc = interrupt_return_epilogue_isa ? {interrupt_return_epilogue_pc[31:1], 1'b1} : interrupt_return_epilogue_pc;
            st_next.status[IRE_ST_IE] = 1'b0;
            st_next.mem_addr = sp_cur + IRE_STK_STATUS;
            st_next.sel      = IRE_SEL_STATUS;
            st_next.state    = IRE_LOAD;
          end
        end
      end
      IRE_LOAD: begin
        if (!st_reg.mem_req) begin
          if (st_reg.mem_addr[1:0] != 2'b00) begin
            st_next.exc_valid = 1'b1;
            st_next.exc_code  = IRE_EX_ADDR;
            st_next.fault     = st_reg.mem_addr;
            st_next.state     = IRE_IDLE;
          end else begin
            st_next.mem_req = 1'b1;
          end
        end else if (mem_ack) begin
          st_next.mem_req = 1'b0;
          if (mem_fault != IRE_MF_NONE) begin
            st_next.exc_valid = 1'b1;
            st_next.exc_code  = mem_fault;
            st_next.state     = IRE_IDLE;
            if (mem_fault == IRE_MF_PRIV || mem_fault == IRE_MF_REFIL ||
                mem_fault == IRE_MF_INVAL) begin
              st_next.fault = st_reg.mem_addr;
            end
            if (mem_fault == IRE_MF_REFIL || mem_fault == IRE_MF_INVAL) begin
              st_next.tfault = st_reg.mem_addr;
            end
            if (mem_fault == IRE_MF_CACHE) begin
              st_next.cfault = st_reg.mem_addr;
            end
          end else begin
            unique case (st_reg.sel)
              IRE_SEL_STATUS: begin
                st_next.status = mem_rdata;
                st_next.hazard = 1'b1;
                if (ret_go) begin
                  st_next.mem_addr = sp_cur + IRE_STK_SHADOW;
                  st_next.sel      = IRE_SEL_SHADOW;
                end else begin
                  st_next.eic_accept = 1'b1;
                  st_next.state      = IRE_WAIT;
                end
              end
              IRE_SEL_SHADOW: begin
                st_next.tmp_shadow = mem_rdata;
                st_next.mem_addr   = sp_cur + IRE_STK_EPC;
                st_next.sel        = IRE_SEL_EPC;
              end
              default: begin
                // Returning path completes here
                st_next.exception_pc     = mem_rdata;
                st_next.sp[current_shadow_set] = sp_cur + ire_frame(st_reg.ctrl);
                st_next.shadow  = st_reg.tmp_shadow;
                if (ARCH_REV >= 2 && st_reg.tmp_shadow[IRE_SH_HSS +: 4] != 4'h0 &&
                    !st_reg.status[IRE_ST_BEV] && !st_reg.status[IRE_ST_ERL]) begin
                  st_next.shadow[IRE_SH_CSS +: 4] =
                    st_reg.tmp_shadow[IRE_SH_PSS +: 4];
                end
                st_next.status[IRE_ST_EXL] = 1'b0;
                st_next.link     = 1'b0;
                st_next.ic       = 1'b0;
                st_next.pc       = COMPRESSED ? {mem_rdata[31:1], 1'b0}
                                              : mem_rdata;
                st_next.isa      = COMPRESSED ? mem_rdata[0] : 1'b0;
                st_next.hazard   = 1'b1;
                st_next.redirect = 1'b1;
                st_next.state    = IRE_IDLE;
              end
            endcase
          end
        end
      end
      default: begin
        // Wait for the controller to present the accepted interrupt
        if (eic_updated) begin
          st_next.eic_accept = 1'b0;
          st_next.requested_priority_level       = eic_requested_priority_level;
          st_next.shadow[IRE_SH_ESS +: 4] = eic_ss;
          st_next.sp[current_shadow_set]    = sp_cur + ire_frame(st_reg.ctrl);
          st_next.sp[eic_ss] = sp_cur;
          st_next.shadow[IRE_SH_CSS +: 4] = eic_ss;
          st_next.status[IRE_ST_IPL +: 6] = eic_requested_priority_level;
          if (st_reg.ctrl[IRE_CTL_CLR]) begin
            st_next.status[IRE_ST_EXL]    = 1'b0;
            st_next.status[IRE_ST_KSU +: 2] = 2'b00;
          end
          st_next.ic       = 1'b1;
          st_next.link     = 1'b0;
          st_next.pc       = ire_vector(st_reg.ctrl, st_reg.status,
                                        st_reg.vbase, eic_requested_priority_level);
          st_next.redirect = 1'b1;
          st_next.state    = IRE_IDLE;
        end
      end
    endcase
  end

  // ========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.status <= IRE_STATUS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================
  // Outputs
  assign pready         = 1'b1;
  assign prdata         = st_reg.prdata;
  assign pslverr        = st_reg.pslverr && psel && penable;
  assign flush_next     = st_reg.flush;
  assign exception_return_request   = st_reg.exception_return_req;
  assign hazard_barrier = st_reg.hazard;
  assign redirect_valid = st_reg.redirect;
  assign redirect_pc    = st_reg.pc;
  assign redirect_isa   = st_reg.isa;
  assign busy           = st_reg.state != IRE_IDLE;
  assign mem_req        = st_reg.mem_req;
  assign mem_addr       = st_reg.mem_addr;
  assign eic_accept     = st_reg.eic_accept;
  assign exc_valid      = st_reg.exc_valid;
  assign exc_code       = st_reg.exc_code;

  // ========================================================
  // Assertions
  AST_EXCEPTION_RETURN_PATH: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_return_epilogue_issue && st_reg.state == IRE_IDLE && !wr_acc && !st_reg.ctrl[IRE_CTL_APE])
    |=> exception_return_request && !busy)
    else $error("Disabled prologue did not act as exception return");
  AST_BOOT_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_return_epilogue_issue && st_reg.state == IRE_IDLE && !wr_acc && st_reg.status[IRE_ST_ERL])
    |=> !mem_req && !busy)
    else $error("Stack accessed with error level set");
  AST_EPC_SAVE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.state == IRE_IDLE && $past(st_reg.state) == IRE_IDLE) ##1
    (busy && !$past(busy)) |-> st_reg.exception_pc[0] == $past(interrupt_return_epilogue_isa))
    else $error("Exception PC not saved with ISA bit");
  AST_STATUS_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> mem_addr == sp_cur + IRE_STK_STATUS && !st_reg.status[IRE_ST_IE])
    else $error("Status load address wrong");
  AST_CHAIN_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (eic_accept && !eic_updated) |=> eic_accept && !redirect_valid)
    else $error("Accept dropped before controller update");
  AST_CHAIN_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (eic_accept && eic_updated) |=> st_reg.ic && redirect_valid && !hazard_barrier)
    else $error("Chain did not set flag or made a barrier");
  AST_RET_PC: assert property (@(posedge pclk) disable iff (!presetn)
    (redirect_valid && !st_reg.ic) |-> !redirect_pc[0] && hazard_barrier && !st_reg.link)
    else $error("Return PC bit 0 set or barrier missing");
  AST_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && !mem_req && mem_addr[1:0] != 2'b00 && st_reg.state == IRE_LOAD)
    |=> exc_valid && exc_code == IRE_EX_ADDR && !mem_req)
    else $error("Unaligned stack word not trapped");
  AST_NO_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_return_epilogue_issue && !busy && !wr_acc) |=> flush_next)
    else $error("Next instruction not squashed");
endmodule : ire_epilogue
`default_nettype wire

// ### dv/ire_stack_eic_model.sv
`default_nettype none
// ======================================================
// Stack memory and interrupt controller beside the epilogue
module ire_stack_eic_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Stack memory
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic [2:0]       mem_fault,
  // Interrupt controller
  input  wire logic        eic_accept,
  output logic             eic_updated,
  output logic [5:0]       eic_requested_priority_level,
  output logic [3:0]       eic_ss,
  // Frame words and controller values set by the bench
  input  wire logic [31:0] ws,
  input  wire logic [31:0] wh,
  input  wire logic [31:0] we,
  input  wire logic [5:0]  requested_priority_level_in,
  input  wire logic [3:0]  ss_in,
  input  wire logic [2:0]  fault_in
);
  logic [1:0] cnt;   // Wait states of a load
  logic [1:0] ecnt;  // Delay before the controller updates
  assign eic_requested_priority_level = requested_priority_level_in;  // Level presented for the compare
  // Loads answer after three wait states; idle data is scrambled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mem_ack, mem_rdata, mem_fault, cnt} <= '0;
    end else begin
      mem_ack   <= 1'b0;
      mem_fault <= '0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        cnt <= cnt + 2'd1;
        if (cnt == 2'd2) begin
          cnt       <= '0;
          mem_ack   <= 1'b1;
          mem_fault <= fault_in;
          mem_rdata <= (mem_addr[3:0] == 4'h4) ? ws : (mem_addr[3:0] == 4'h8) ? wh : we;
        end
      end
    end
  end
  // New set shown only with the late update pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {eic_updated, ecnt, eic_ss} <= '0;
    end else begin
      eic_updated <= 1'b0;
      eic_ss      <= ~ss_in;
      if (eic_accept && !eic_updated) begin
        ecnt <= ecnt + 2'd1;
        if (ecnt == 2'd1) begin
          ecnt        <= '0;
          eic_updated <= 1'b1;
          eic_ss      <= ss_in;
        end
      end
    end
  end
endmodule : ire_stack_eic_model
`default_nettype wire

// ### dv/ire_epilogue_bench.sv
`default_nettype none
module ire_epilogue_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ire_pkg::*;
  // ======================================================
  // Signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, interrupt_return_epilogue_issue = 0, interrupt_return_epilogue_isa = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, interrupt_return_epilogue_pc = '0, ws = '0, wh = '0, we = '0;
  logic [31:0] prdata, mem_addr, mem_rdata, redirect_pc, rd, rpc;
  logic pready, pslverr, flush_next, exception_return_request, hazard_barrier, redirect_valid, redirect_isa;
  logic busy, mem_req, mem_ack, eic_accept, eic_updated, exc_valid, err, risa, rhaz, ev, xv;
  logic [2:0] mem_fault, exc_code, xc, fault_in = '0;
  logic [5:0] eic_requested_priority_level, requested_priority_level_in = '0;
  logic [3:0] eic_ss, ss_in = '0;
  int fail_count = 0, cmp_count = 0, flushes;
  logic [31:0] ld[$];
  always #12.5 pclk = ~pclk;
  ire_epilogue i_ire_epilogue (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .interrupt_return_epilogue_issue(interrupt_return_epilogue_issue), .interrupt_return_epilogue_pc(interrupt_return_epilogue_pc), .interrupt_return_epilogue_isa(interrupt_return_epilogue_isa),
    .flush_next(flush_next), .exception_return_request(exception_return_request), .hazard_barrier(hazard_barrier),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .redirect_isa(redirect_isa),
    .busy(busy), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_fault(mem_fault), .eic_requested_priority_level(eic_requested_priority_level), .eic_ss(eic_ss),
    .eic_updated(eic_updated), .eic_accept(eic_accept), .exc_valid(exc_valid),
    .exc_code(exc_code));
  ire_stack_eic_model i_ire_stack_eic_model (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fault(mem_fault),
    .eic_accept(eic_accept), .eic_updated(eic_updated), .eic_requested_priority_level(eic_requested_priority_level),
    .eic_ss(eic_ss), .ws(ws), .wh(wh), .we(we), .requested_priority_level_in(requested_priority_level_in), .ss_in(ss_in),
    .fault_in(fault_in));
  // Log every completed stack load
  always @(posedge pclk) if (mem_req === 1'b1 && mem_ack === 1'b1) ld.push_back(mem_addr);
  // ======================================================
  // Shared tasks
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer, entered right after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    for (int n = 0; n <= 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (n == 50) begin fail_count++; test_done(); end
    end
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  // Issue one return and wait for its outcome pulse
  task fire(input logic [31:0] pc, input logic isa);
    ld.delete(); flushes = 0;
    interrupt_return_epilogue_issue <= 1; interrupt_return_epilogue_pc <= pc; interrupt_return_epilogue_isa <= isa; // Never from a delay slot
    @(posedge pclk) interrupt_return_epilogue_issue <= 0;
    for (int n = 0; n <= 300; n++) begin
      @(negedge pclk);
      if (flush_next === 1'b1) flushes++;
      if (redirect_valid === 1'b1 || exc_valid === 1'b1 || exception_return_request === 1'b1) break;
      if (n == 300) begin fail_count++; test_done(); end
    end
    rpc = redirect_pc; risa = redirect_isa; rhaz = hazard_barrier;
    ev = exception_return_request; xv = exc_valid; xc = exc_code;
    @(posedge pclk);
    chk("flush", flushes, 1);
  endtask : fire
  // ======================================================
  // Scenarios
  task s_boot;
    apb(0, IRE_OFF_STATUS, 0); chk("status", rd, 32'h0040_0004);
    apb(1, IRE_OFF_CTRL, 32'h0000_0001); fire(32'h0000_3000, 0);
    chk("exception_return", ev, 1);
    chk("loads", ld.size(), 0);
  endtask : s_boot
  task s_ape_off;
    apb(1, IRE_OFF_STATUS, 0); apb(1, IRE_OFF_CTRL, 0); fire(32'h0000_3000, 0);
    chk("exception_return", ev, 1);
  endtask : s_ape_off
  task s_return;
    ws <= 32'h0000_1402; wh <= 32'h0000_0085; we <= 32'h0000_2001;
    apb(1, IRE_OFF_CTRL, 32'h0000_0601); apb(1, IRE_OFF_SP, 32'h0000_1000);
    fire(32'h0000_3000, 0);
    chk("pc", rpc, 32'h0000_2000); chk("isa", risa, 1);
    chk("hazard", rhaz, 1);
    chk("ld0", ld[0], 32'h0000_1004);
    chk("ld1", ld[1], 32'h0000_1008); chk("ld2", ld[2], 32'h0000_1000);
    apb(0, IRE_OFF_SP, 0); chk("sp", rd, 32'h0000_100C);
    apb(0, IRE_OFF_STATUS, 0); chk("status", rd, 32'h0000_1400);
    apb(0, IRE_OFF_SHADOW, 0); chk("shadow", rd, 32'h0000_0085);
    apb(0, IRE_OFF_CAUSE, 0); chk("flags", {rd[25], rd[0]}, 0);
  endtask : s_return
  task s_chain;
    ws <= 32'h0000_0C12; requested_priority_level_in <= 6'd7; ss_in <= 4'd5;
    apb(1, IRE_OFF_CTRL, 32'h0000_0607); apb(1, IRE_OFF_VBASE, 32'h8001_0000);
    apb(1, IRE_OFF_SP, 32'h0000_1000); fire(32'h0000_3000, 0);
    chk("vector", rpc, 32'h8001_0180);
    chk("hazard", rhaz, 0);
    chk("loads", ld.size(), 1);
    apb(0, IRE_OFF_STATUS, 0); chk("status", rd, 32'h0000_1C00);
    apb(0, IRE_OFF_CAUSE, 0); chk("chained", rd[25], 1);
    chk("requested_priority_level", rd[15:10], 7);
    apb(0, IRE_OFF_SHADOW, 0); chk("css", rd[3:0], 5);
    apb(0, IRE_OFF_SP, 0); chk("sp", rd, 32'h0000_1000);
    // Vectored offsets: zero spacing, then spacing of one 32-byte unit
    apb(1, IRE_OFF_CTRL, 32'h0000_060F); fire(32'h0000_3000, 0);
    chk("vector_int", rpc, 32'h8001_0200);
    apb(1, IRE_OFF_CTRL, 32'h0000_061F); fire(32'h0000_3000, 0);
    chk("vector_vs", rpc, 32'h8001_02E0);
  endtask : s_chain
  task s_faults;
    apb(1, IRE_OFF_SP, 32'h0000_1000);
    fault_in <= IRE_MF_CACHE; fire(32'h0000_3000, 1); fault_in <= IRE_MF_NONE;
    chk("code", {xv, xc}, {1'b1, IRE_MF_CACHE});
    apb(0, IRE_OFF_EPC, 0); chk("epc", rd, 32'h0000_3001);
    apb(0, IRE_OFF_CFAULT, 0); chk("cfault", rd, 32'h0000_1004);
    apb(1, IRE_OFF_SP, 32'h0000_1002); fire(32'h0000_3000, 0);
    chk("code", {xv, xc}, {1'b1, IRE_EX_ADDR}); chk("loads", ld.size(), 0);
    apb(0, IRE_OFF_FAULT, 0); chk("fault", rd, 32'h0000_1006);
    apb(0, 12'h0FC, 0); chk("unmapped", {err, rd}, {1'b1, 32'h0});
  endtask : s_faults
  // ======================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    s_boot();
    s_ape_off();
    s_chain();
    s_return();
    s_faults();
    test_done();
  end
endmodule : ire_epilogue_bench
`default_nettype wire
